// ---- src/scr_pkg.sv ----
// constants and types shared by the serial channel register block
package scr_pkg;
    localparam int SCR_NCH = 3;
    localparam int SCR_AW = 14;
    localparam int SCR_RXW = 9;
    localparam int SCR_FIFO_DEPTH = 16;
    // -----------------------------------------------------------------
    // register indices; byte address is four times the index
    // -----------------------------------------------------------------
    localparam logic [2:0][11:0] SCR_CR_IDX = {12'h211, 12'h209, 12'h201};
    localparam logic [2:0][11:0] SCR_M0_IDX = {12'h212, 12'h20a, 12'h202};
    localparam logic [2:0][11:0] SCR_M1_IDX = {12'h215, 12'h20d, 12'h205};
    localparam logic [7:0] SCR_RESET_BYTE = 8'h00;
    // -----------------------------------------------------------------
    // control_status fields
    // -----------------------------------------------------------------
    localparam int SCR_CR_NINTH = 7;
    localparam int SCR_CR_EVEN = 6;
    localparam int SCR_CR_PE = 5;
    localparam int SCR_CR_OVR = 4;
    localparam int SCR_CR_PAR = 3;
    localparam int SCR_CR_FRM = 2;
    localparam int SCR_CR_EDGE = 1;
    localparam int SCR_CR_SRC = 0;
    // software may write only even, parity enable, edge and clock source
    localparam logic [7:0] SCR_CR_WMASK = 8'h63;
    // write-only parity enable and clock source read back as zero
    localparam logic [7:0] SCR_CR_RMASK = 8'hde;
    localparam logic [7:0] SCR_CR_ERRS = 8'h1c;
    // -----------------------------------------------------------------
    // mode fields
    // -----------------------------------------------------------------
    localparam int SCR_M0_TX9 = 7;
    localparam int SCR_M0_FLOW = 6;
    localparam int SCR_M0_RXE = 5;
    localparam int SCR_M0_WU = 4;
    localparam int SCR_M0_FMT = 2;
    localparam int SCR_M0_CLK = 0;
    localparam int SCR_M1_IDLE = 7;
    localparam int SCR_M1_FDX = 6;
    localparam logic [7:0] SCR_M1_MASK = 8'hc0;
    localparam logic [1:0] SCR_FMT_SHIFT = 2'h0;
    localparam logic [1:0] SCR_FMT_7 = 2'h1;
    localparam logic [1:0] SCR_FMT_8 = 2'h2;
    localparam logic [1:0] SCR_FMT_9 = 2'h3;
    localparam logic [1:0] SCR_CLK_TIMER = 2'h0;
    localparam logic [1:0] SCR_CLK_BRG = 2'h1;
    localparam logic [1:0] SCR_CLK_SYS = 2'h2;
    localparam logic [1:0] SCR_CLK_EXT = 2'h3;
    localparam logic [1:0] SCR_RESP_OKAY = 2'h0;
    localparam logic [1:0] SCR_RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {SCR_IDLE = 2'b01, SCR_RESP = 2'b10} scr_bus_e;
    function automatic logic [SCR_AW-1:0] scr_addr(input logic [11:0] idx);
        scr_addr = {idx, 2'b00};
    endfunction
endpackage

// ---- src/scr_top.sv ----
// serial channel control registers with receive word buffers
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps

// --------------------
// receive word buffer
// --------------------
module scr_fifo
#(
    parameter int W = scr_pkg::SCR_RXW,
    parameter int D = scr_pkg::SCR_FIFO_DEPTH
)
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(D);
    localparam logic [PW:0] FULL = (PW+1)'(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
        logic in_ready;
        logic out_valid;
        logic [W-1:0] out_data;
    } scr_fifo_s;
    scr_fifo_s s_r;
    scr_fifo_s s_nxt;
    logic push;
    logic pop;

    always_comb
    begin
        s_nxt = s_r;
        push = in_valid && s_r.in_ready;
        pop = out_ready && s_r.out_valid;
        if (push)
        begin
            s_nxt.mem[s_r.wp] = in_data;
            s_nxt.wp = s_r.wp + 1'b1;
        end
        if (pop)
        begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
        if (push && !pop)
        begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end
        else if (pop && !push)
        begin
            s_nxt.cnt = s_r.cnt - 1'b1;
        end
        // flags and head word registered so the ports come from flops
        s_nxt.in_ready = s_nxt.cnt != FULL;
        s_nxt.out_valid = s_nxt.cnt != '0;
        s_nxt.out_data = s_nxt.mem[s_nxt.rp];
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign in_ready = s_r.in_ready;
    assign out_valid = s_r.out_valid;
    assign out_data = s_r.out_data;
endmodule

// Contract
// - format field picks shift, 7, 8, 9-bit
// - async clock field picks timer, generator, system, pin
// - shift clock source: generator or pin
// - shift edge select: rising or falling
// - parity enable and odd or even sense
// - error flags read one once detected
// - a control read clears that channel's error flags
// - flow gate makes clear-to-send hold transmit
// - receiver enable admits or blocks frames
// - wakeup enable turns wakeup receive on
// - idle run bit and duplex select
// - 8-bit parity into ninth bits
// - stop majority zero sets framing flag
module scr_top
import scr_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [scr_pkg::SCR_AW-1:0] AWADDR,
    input wire logic [2:0] AWPROT,
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [scr_pkg::SCR_AW-1:0] ARADDR,
    input wire logic [2:0] ARPROT,
    output logic RVALID,
    input wire logic RREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    input wire logic [scr_pkg::SCR_NCH-1:0] CTS_N,
    input wire logic IDLE_REQ,
    input wire logic [scr_pkg::SCR_NCH-1:0] RX_FRAME,
    input wire logic [scr_pkg::SCR_NCH-1:0][8:0] RX_DATA,
    input wire logic [scr_pkg::SCR_NCH-1:0][2:0] RX_STOP,
    input wire logic [scr_pkg::SCR_NCH-1:0] TX_LOAD,
    input wire logic [scr_pkg::SCR_NCH-1:0][7:0] TX_BYTE,
    output logic [scr_pkg::SCR_NCH-1:0][8:0] RX_WORD,
    output logic [scr_pkg::SCR_NCH-1:0] RX_VALID,
    input wire logic [scr_pkg::SCR_NCH-1:0] RX_READY,
    output logic [scr_pkg::SCR_NCH-1:0][1:0] FORMAT,
    output logic [scr_pkg::SCR_NCH-1:0][1:0] CLK_SOURCE,
    output logic [scr_pkg::SCR_NCH-1:0] EDGE_FALL,
    output logic [scr_pkg::SCR_NCH-1:0] PARITY_ON,
    output logic [scr_pkg::SCR_NCH-1:0] PARITY_EVEN,
    output logic [scr_pkg::SCR_NCH-1:0] TX_ALLOW,
    output logic [scr_pkg::SCR_NCH-1:0] TX_NINTH,
    output logic [scr_pkg::SCR_NCH-1:0] RX_ON,
    output logic [scr_pkg::SCR_NCH-1:0] WAKE_ON,
    output logic [scr_pkg::SCR_NCH-1:0] RUN,
    output logic [scr_pkg::SCR_NCH-1:0] FULL_DUPLEX
);
    import scr_pkg::*;

    // --------------------
    // state
    // --------------------
    typedef struct packed {
        logic [SCR_NCH-1:0][7:0] cr;
        logic [SCR_NCH-1:0][7:0] m0;
        logic [SCR_NCH-1:0][7:0] m1;
        logic [SCR_NCH-1:0] cts_s1;
        logic [SCR_NCH-1:0] cts_s2;
        scr_bus_e wst;
        scr_bus_e rst;
        logic aw_got;
        logic w_got;
        logic [SCR_AW-1:0] waddr;
        logic [7:0] wdata;
        logic wlane;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [SCR_NCH-1:0][1:0] fmt;
        logic [SCR_NCH-1:0][1:0] clk;
        logic [SCR_NCH-1:0] edge_fall;
        logic [SCR_NCH-1:0] par_on;
        logic [SCR_NCH-1:0] par_even;
        logic [SCR_NCH-1:0] tx_allow;
        logic [SCR_NCH-1:0] rx_on;
        logic [SCR_NCH-1:0] wake_on;
        logic [SCR_NCH-1:0] run;
        logic [SCR_NCH-1:0] fdx;
    } scr_st_s;
    scr_st_s s_r;
    scr_st_s s_nxt;
    logic [SCR_NCH-1:0] push;
    logic [SCR_NCH-1:0] fifo_ready;

    // parity bit over a byte; odd sense makes the total count odd
    function automatic logic par_of(input logic [7:0] v, input logic even);
        par_of = even ? ^v : ~^v;
    endfunction

    // --------------------
    // next state
    // --------------------
    always_comb
    begin
        logic [1:0] fmt;
        logic [8:0] d;
        logic hit;
        logic bad;
        fmt = '0;
        d = '0;
        hit = 1'b0;
        bad = 1'b0;
        s_nxt = s_r;
        push = '0;
        s_nxt.cts_s1 = CTS_N;
        s_nxt.cts_s2 = s_r.cts_s1;

        // read side: the read clears flags before any event is merged
        case (s_r.rst)
            SCR_IDLE:
            begin
                if (ARVALID && s_r.arready)
                begin
                    s_nxt.rdata = '0;
                    s_nxt.rresp = SCR_RESP_SLVERR;
                    for (int ch = 0; ch < SCR_NCH; ch++)
                    begin
                        if (ARADDR == scr_addr(SCR_CR_IDX[ch]))
                        begin
                            s_nxt.rdata = s_r.cr[ch] & SCR_CR_RMASK;
                            s_nxt.rresp = SCR_RESP_OKAY;
                            s_nxt.cr[ch] = s_r.cr[ch] & ~SCR_CR_ERRS;
                        end
                        else if (ARADDR == scr_addr(SCR_M0_IDX[ch]))
                        begin
                            s_nxt.rdata = s_r.m0[ch];
                            s_nxt.rresp = SCR_RESP_OKAY;
                        end
                        else if (ARADDR == scr_addr(SCR_M1_IDX[ch]))
                        begin
                            s_nxt.rdata = s_r.m1[ch];
                            s_nxt.rresp = SCR_RESP_OKAY;
                        end
                    end
                    s_nxt.rvalid = 1'b1;
                    s_nxt.rst = SCR_RESP;
                end
            end
            SCR_RESP:
            begin
                if (RREADY)
                begin
                    s_nxt.rvalid = 1'b0;
                    s_nxt.rst = SCR_IDLE;
                end
            end
            default:
            begin
                s_nxt.rst = SCR_IDLE;
            end
        endcase

        // write side: address and data taken in either order
        if (AWVALID && s_r.awready)
        begin
            s_nxt.aw_got = 1'b1;
            s_nxt.waddr = AWADDR;
        end
        if (WVALID && s_r.wready)
        begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = WDATA[7:0];
            s_nxt.wlane = WSTRB[0];
        end
        case (s_r.wst)
            SCR_IDLE:
            begin
                if (s_nxt.aw_got && s_nxt.w_got)
                begin
                    for (int ch = 0; ch < SCR_NCH; ch++)
                    begin
                        if (s_nxt.waddr == scr_addr(SCR_CR_IDX[ch]))
                        begin
                            hit = 1'b1;
                            // flags and received bit are left alone
                            if (s_nxt.wlane)
                            begin
                                s_nxt.cr[ch] = (s_nxt.cr[ch] & ~SCR_CR_WMASK)
                                    | (s_nxt.wdata & SCR_CR_WMASK);
                            end
                        end
                        else if (s_nxt.waddr == scr_addr(SCR_M0_IDX[ch]))
                        begin
                            hit = 1'b1;
                            if (s_nxt.wlane)
                            begin
                                s_nxt.m0[ch] = s_nxt.wdata;
                            end
                        end
                        else if (s_nxt.waddr == scr_addr(SCR_M1_IDX[ch]))
                        begin
                            hit = 1'b1;
                            if (s_nxt.wlane)
                            begin
                                s_nxt.m1[ch] = s_nxt.wdata & SCR_M1_MASK;
                            end
                        end
                    end
                    s_nxt.bresp = hit ? SCR_RESP_OKAY : SCR_RESP_SLVERR;
                    s_nxt.bvalid = 1'b1;
                    s_nxt.aw_got = 1'b0;
                    s_nxt.w_got = 1'b0;
                    s_nxt.wst = SCR_RESP;
                end
            end
            SCR_RESP:
            begin
                if (BREADY)
                begin
                    s_nxt.bvalid = 1'b0;
                    s_nxt.wst = SCR_IDLE;
                end
            end
            default:
            begin
                s_nxt.wst = SCR_IDLE;
            end
        endcase
        s_nxt.awready = !s_nxt.aw_got && s_nxt.wst == SCR_IDLE;
        s_nxt.wready = !s_nxt.w_got && s_nxt.wst == SCR_IDLE;
        s_nxt.arready = s_nxt.rst == SCR_IDLE;

        // per channel events; they come last so a set beats a clear
        for (int ch = 0; ch < SCR_NCH; ch++)
        begin
            fmt = s_nxt.m0[ch][SCR_M0_FMT +: 2];
            d = RX_DATA[ch];
            // a transmit load after a software write wins the ninth bit
            if (TX_LOAD[ch] && fmt == SCR_FMT_8 && s_nxt.cr[ch][SCR_CR_PE])
            begin
                s_nxt.m0[ch][SCR_M0_TX9] = par_of(TX_BYTE[ch],
                    s_nxt.cr[ch][SCR_CR_EVEN]);
            end
            if (RX_FRAME[ch] && s_nxt.m0[ch][SCR_M0_RXE])
            begin
                // in 9-bit wakeup mode only address frames get through
                bad = s_nxt.m0[ch][SCR_M0_WU] && fmt == SCR_FMT_9 && !d[8];
                if (!bad)
                begin
                    push[ch] = 1'b1;
                    s_nxt.cr[ch][SCR_CR_NINTH] = d[8];
                    if (!fifo_ready[ch])
                    begin
                        s_nxt.cr[ch][SCR_CR_OVR] = 1'b1;
                    end
                    if (s_nxt.cr[ch][SCR_CR_PE] && fmt == SCR_FMT_8
                        && d[8] != par_of(d[7:0], s_nxt.cr[ch][SCR_CR_EVEN]))
                    begin
                        s_nxt.cr[ch][SCR_CR_PAR] = 1'b1;
                    end
                    if (s_nxt.cr[ch][SCR_CR_PE] && fmt == SCR_FMT_7
                        && d[7] != par_of({1'b0, d[6:0]}, s_nxt.cr[ch][SCR_CR_EVEN]))
                    begin
                        s_nxt.cr[ch][SCR_CR_PAR] = 1'b1;
                    end
                    if (fmt != SCR_FMT_SHIFT && ((!RX_STOP[ch][0] && !RX_STOP[ch][1])
                        || (!RX_STOP[ch][0] && !RX_STOP[ch][2])
                        || (!RX_STOP[ch][1] && !RX_STOP[ch][2])))
                    begin
                        s_nxt.cr[ch][SCR_CR_FRM] = 1'b1;
                    end
                end
            end
            // engine controls, all registered
            s_nxt.fmt[ch] = fmt;
            if (fmt == SCR_FMT_SHIFT)
            begin
                // the prescale limit on the generator is software's to keep
                s_nxt.clk[ch] = s_nxt.cr[ch][SCR_CR_SRC] ? SCR_CLK_EXT : SCR_CLK_BRG;
            end
            else
            begin
                s_nxt.clk[ch] = s_nxt.m0[ch][SCR_M0_CLK +: 2];
            end
            s_nxt.edge_fall[ch] = s_nxt.cr[ch][SCR_CR_EDGE];
            s_nxt.par_on[ch] = s_nxt.cr[ch][SCR_CR_PE]
                && (fmt == SCR_FMT_7 || fmt == SCR_FMT_8);
            s_nxt.par_even[ch] = s_nxt.cr[ch][SCR_CR_EVEN];
            s_nxt.tx_allow[ch] = !s_nxt.m0[ch][SCR_M0_FLOW] || !s_r.cts_s2[ch];
            s_nxt.rx_on[ch] = s_nxt.m0[ch][SCR_M0_RXE];
            s_nxt.wake_on[ch] = s_nxt.m0[ch][SCR_M0_WU];
            s_nxt.run[ch] = !IDLE_REQ || s_nxt.m1[ch][SCR_M1_IDLE];
            s_nxt.fdx[ch] = s_nxt.m1[ch][SCR_M1_FDX];
        end
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            s_r <= '0;
            s_r.wst <= SCR_IDLE;
            s_r.rst <= SCR_IDLE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // --------------------
    // receive buffers; a full buffer drops the frame as an overrun
    // --------------------
    for (genvar ch = 0; ch < SCR_NCH; ch++)
    begin : g_rx
        scr_fifo #(.W(SCR_RXW), .D(SCR_FIFO_DEPTH)) u_fifo
        (
            .MCLK(MCLK),
            .RST_N(RST_N),
            .in_valid(push[ch]),
            .in_ready(fifo_ready[ch]),
            .in_data(RX_DATA[ch]),
            .out_valid(RX_VALID[ch]),
            .out_ready(RX_READY[ch]),
            .out_data(RX_WORD[ch])
        );
    end

    // --------------------
    // outputs
    // --------------------
    assign AWREADY = s_r.awready;
    assign WREADY = s_r.wready;
    assign BVALID = s_r.bvalid;
    assign BRESP = s_r.bresp;
    assign ARREADY = s_r.arready;
    assign RVALID = s_r.rvalid;
    assign RRESP = s_r.rresp;
    assign RDATA = {24'h000000, s_r.rdata};
    assign FORMAT = s_r.fmt;
    assign CLK_SOURCE = s_r.clk;
    assign EDGE_FALL = s_r.edge_fall;
    assign PARITY_ON = s_r.par_on;
    assign PARITY_EVEN = s_r.par_even;
    assign TX_ALLOW = s_r.tx_allow;
    assign RX_ON = s_r.rx_on;
    assign WAKE_ON = s_r.wake_on;
    assign RUN = s_r.run;
    assign FULL_DUPLEX = s_r.fdx;
    for (genvar ch = 0; ch < SCR_NCH; ch++)
    begin : g_tx9
        assign TX_NINTH[ch] = s_r.m0[ch][SCR_M0_TX9];
    end
endmodule

// ---- verification/scr_remote.sv ----
// far side serial device model: received frames and clear-to-send
`timescale 1ns/100ps
module scr_remote
(
    input wire logic clk,
    output logic [scr_pkg::SCR_NCH-1:0] frame = '0,
    output logic [scr_pkg::SCR_NCH-1:0][8:0] data = '0,
    output logic [scr_pkg::SCR_NCH-1:0][2:0] stop = '0,
    output logic [scr_pkg::SCR_NCH-1:0] cts_n = '0
);
    import scr_pkg::*;
    // --------------------
    // frame delivery
    // --------------------
    // idle lines show the inverse, so stale data never looks valid
    task automatic send(input int c, input logic [8:0] d, input logic [2:0] s);
        frame[c] <= 1'b1;
        data[c] <= d;
        stop[c] <= s;
        @(posedge clk);
        frame[c] <= 1'b0;
        data[c] <= ~d;
        stop[c] <= ~s;
        @(posedge clk);
    endtask
    task automatic cts(input int c, input logic v);
        cts_n[c] <= v;
    endtask
endmodule

// ---- verification/scr_sva.sv ----
// assertions on bus handshakes and control outputs of the register block
`timescale 1ns/100ps
module scr_sva
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic [1:0] BRESP,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic [31:0] RDATA,
    input wire logic [scr_pkg::SCR_NCH-1:0] CTS_N,
    input wire logic IDLE_REQ,
    input wire logic [scr_pkg::SCR_NCH-1:0] RX_VALID,
    input wire logic [scr_pkg::SCR_NCH-1:0] RX_READY,
    input wire logic [scr_pkg::SCR_NCH-1:0][8:0] RX_WORD,
    input wire logic [scr_pkg::SCR_NCH-1:0] TX_ALLOW,
    input wire logic [scr_pkg::SCR_NCH-1:0] RUN
);
    import scr_pkg::*;
    // --------------------
    // properties
    // --------------------
    default clocking dc @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);
    a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read got no answer");
    a_rdata_byte: assert property (RVALID |-> RDATA[31:8] == 24'h0)
        else $error("read data above byte");
    a_rvalid_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read answer dropped");
    a_ar_refused: assert property (RVALID |-> !ARREADY)
        else $error("address taken during answer");
    a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |=> BVALID)
        else $error("write got no answer");
    a_bvalid_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write answer dropped");
    a_cts_opens: assert property (!CTS_N[2] [*4] |-> TX_ALLOW[2])
        else $error("transmit held with clear-to-send");
    a_run_awake: assert property ($past(RST_N) && !$past(IDLE_REQ) |-> RUN[0])
        else $error("channel stopped outside idle");
    a_word_hold: assert property (RX_VALID[0] && !RX_READY[0] |=> $stable(RX_WORD[0]))
        else $error("buffer head changed while stalled");
    c_write: cover property (BVALID && BREADY);
    c_read: cover property (RVALID && RREADY);
    c_pop: cover property (RX_VALID[0] && RX_READY[0]);
    c_gate: cover property (CTS_N[2] && !TX_ALLOW[2]);
endmodule
bind scr_top scr_sva u_sva (
    .MCLK, .RST_N, .AWVALID, .AWREADY, .WVALID, .WREADY, .BVALID, .BREADY, .BRESP,
    .ARVALID, .ARREADY, .RVALID, .RREADY, .RDATA, .CTS_N, .IDLE_REQ, .RX_VALID,
    .RX_READY, .RX_WORD, .TX_ALLOW, .RUN
);

// ---- verification/scr_top_test.sv ----
// self-checking bench for the serial channel register block
`timescale 1ns/100ps
module scr_top_test;
    import scr_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic idle_req = 1'b0;
    logic [SCR_AW-1:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [SCR_NCH-1:0] tx_load = '0, rx_ready = '0;
    logic [SCR_NCH-1:0][7:0] tx_byte = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [SCR_NCH-1:0] cts_n, rx_frame, rx_valid, edge_fall, par_on, par_even;
    logic [SCR_NCH-1:0] tx_allow, tx_ninth, rx_on, wake_on, run, fdx;
    logic [SCR_NCH-1:0][8:0] rx_data, rx_word;
    logic [SCR_NCH-1:0][2:0] rx_stop;
    logic [SCR_NCH-1:0][1:0] fmt, clk_src;
    int checked = 0, mismatches = 0, cycles = 0;
    scr_top dut (
        .MCLK(mclk), .RST_N(rst_n), .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr),
        .AWPROT(3'h0), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(4'hf),
        .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid),
        .ARREADY(arready), .ARADDR(araddr), .ARPROT(3'h0), .RVALID(rvalid),
        .RREADY(rready), .RDATA(rdata), .RRESP(rresp), .CTS_N(cts_n), .IDLE_REQ(idle_req),
        .RX_FRAME(rx_frame), .RX_DATA(rx_data), .RX_STOP(rx_stop), .TX_LOAD(tx_load),
        .TX_BYTE(tx_byte), .RX_WORD(rx_word), .RX_VALID(rx_valid), .RX_READY(rx_ready),
        .FORMAT(fmt), .CLK_SOURCE(clk_src), .EDGE_FALL(edge_fall), .PARITY_ON(par_on),
        .PARITY_EVEN(par_even), .TX_ALLOW(tx_allow), .TX_NINTH(tx_ninth), .RX_ON(rx_on),
        .WAKE_ON(wake_on), .RUN(run), .FULL_DUPLEX(fdx)
    );
    scr_remote far (.clk(mclk), .frame(rx_frame), .data(rx_data), .stop(rx_stop),
        .cts_n(cts_n));
    // --------------------
    // bus and compare tasks
    // --------------------
    initial forever #5 mclk = ~mclk;
    task automatic stop_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            stop_test;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic settle;
        repeat (2) @(posedge mclk);
    endtask
    // word accesses only, never bit tests or read-modify-write
    // prescaler never slow: generator clocks legal
    task automatic wr(input logic [11:0] i, input logic [7:0] d,
        input logic [1:0] r = SCR_RESP_OKAY);
        @(posedge mclk);
        awaddr <= {i, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (!bvalid);
        bready <= 1'b0;
        chk(bresp, r);
    endtask
    task automatic rd(input logic [11:0] i, input logic [7:0] e,
        input logic [1:0] r = SCR_RESP_OKAY);
        @(posedge mclk);
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (!rvalid);
        rready <= 1'b0;
        chk(rdata, {24'h0, e});
        chk(rresp, r);
    endtask
    // --------------------
    // scenarios
    // --------------------
    task automatic t_regs;
        for (int c = 0; c < SCR_NCH; c++)
        begin
            rd(SCR_CR_IDX[c], 8'h00);
            rd(SCR_M0_IDX[c], 8'h00);
            rd(SCR_M1_IDX[c], 8'h00);
        end
        rd(12'h203, 8'h00, SCR_RESP_SLVERR);
        wr(12'h203, 8'h5a, SCR_RESP_SLVERR);
        for (int k = 0; k < 16; k++)
        begin
            wr(SCR_M0_IDX[1], {4'h3, k[3:0]});
            settle;
            chk(fmt[1], k[3:2]);
            chk(clk_src[1], (k[3:2] == 2'h0) ? SCR_CLK_BRG : k[1:0]);
            chk({rx_on[1], wake_on[1]}, 2'h3);
            rd(SCR_M0_IDX[1], {4'h3, k[3:0]});
        end
        wr(SCR_M0_IDX[1], 8'h00);
        settle;
        chk({rx_on[1], wake_on[1]}, 2'h0);
        for (int k = 0; k < 2; k++)
        begin
            wr(SCR_CR_IDX[1], {8{k == 0}});
            settle;
            chk({par_on[1], par_even[1], edge_fall[1]}, {1'b0, {2{k == 0}}});
            chk(clk_src[1], {k == 0, 1'b1});
            rd(SCR_CR_IDX[1], {1'b0, k == 0, 4'h0, k == 0, 1'b0});
        end
        $display("t_regs done");
    endtask
    task automatic t_fifo;
        int got;
        got = 0;
        wr(SCR_M0_IDX[0], 8'h28);
        for (int k = 0; k < 17; k++)
            far.send(0, {1'b0, k[7:0]}, 3'h7);
        rd(SCR_CR_IDX[0], 8'h10);
        rx_ready[0] <= 1'b1;
        for (int n = 0; n < 40 && got < 16; n++)
        begin
            @(posedge mclk);
            if (rx_ready[0] && rx_valid[0])
            begin
                chk(rx_word[0], got);
                got++;
            end
        end
        chk(got, 16);
        settle;
        chk(rx_valid[0], 1'b0);
        wr(SCR_M0_IDX[0], 8'h08);
        far.send(0, 9'h100, 3'h0);
        rd(SCR_CR_IDX[0], 8'h00);
        chk(rx_valid[0], 1'b0);
        wr(SCR_M0_IDX[0], 8'h3c);
        far.send(0, 9'h0aa, 3'h0);
        rd(SCR_CR_IDX[0], 8'h00);
        far.send(0, 9'h1aa, 3'h7);
        rd(SCR_CR_IDX[0], 8'h80);
        $display("t_fifo done");
    endtask
    task automatic t_err;
        wr(SCR_CR_IDX[0], 8'h20);
        wr(SCR_M0_IDX[0], 8'h28);
        far.send(0, 9'h101, 3'h1);
        rd(SCR_CR_IDX[0], 8'h8c);
        rd(SCR_CR_IDX[0], 8'h80);
        far.send(0, 9'h001, 3'h6);
        rd(SCR_CR_IDX[0], 8'h00);
        for (int e = 0; e < 2; e++)
        begin
            wr(SCR_CR_IDX[0], (e == 1) ? 8'h60 : 8'h20);
            tx_byte[0] <= 8'h03;
            tx_load[0] <= 1'b1;
            @(posedge mclk);
            tx_load[0] <= 1'b0;
            settle;
            chk(tx_ninth[0], e == 0);
            chk({par_on[0], par_even[0]}, {1'b1, e == 1});
            rd(SCR_M0_IDX[0], {e == 0, 7'h28});
        end
        $display("t_err done");
    endtask
    task automatic t_gate;
        wr(SCR_M0_IDX[2], 8'h40);
        far.cts(2, 1'b1);
        repeat (5) @(posedge mclk);
        chk(tx_allow[2], 1'b0);
        wr(SCR_M0_IDX[2], 8'h00);
        settle;
        chk(tx_allow[2], 1'b1);
        idle_req <= 1'b1;
        wr(SCR_M1_IDX[0], 8'hff);
        rd(SCR_M1_IDX[0], 8'hc0);
        chk({run[0], fdx[0]}, 2'h3);
        wr(SCR_M1_IDX[0], 8'h00);
        settle;
        chk({run[0], fdx[0]}, 2'h0);
        idle_req <= 1'b0;
        settle;
        chk(run[0], 1'b1);
        $display("t_gate done");
    endtask
    initial
    begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs;
        t_fifo;
        t_err;
        t_gate;
        stop_test;
    end
endmodule
